// ---- verilog/sdl_pkg.sv ----
package sdl_pkg;
    localparam int NUM_CH = 8;
    localparam int WORD_W = 16;
    localparam int MAIN_W = 10;
    localparam int SUB_W = 8;
    // word field positions and frame bit count
    localparam int FINE_SEL_BIT = 15;
    localparam int SEL_LO_BIT = 14;
    localparam int SEL_HI_BIT = 13;
    localparam int ADDR_MSB = 12;
    localparam int ADDR_LSB = 10;
    localparam int BIAS_MSB = 9;
    localparam int BIAS_LSB = 8;
    localparam int CODING_BIT = 6;
    localparam int PWR_BIT = 5;
    localparam int ALL_CHAN_STANDBY_N_BIT = 4;
    localparam int ALL_CLR_BIT = 3;
    localparam int CH_CHAN_STANDBY_N_BIT = 4;
    localparam int CH_CLR_BIT = 3;
    localparam int MAIN_MSB = 9;
    localparam int SUB_MSB = 9;
    localparam int SUB_LSB = 2;
    localparam logic [4:0] BIT_CNT_LAST = 5'h10;
    // reset values and clear codes
    localparam logic RST_CODING = 1'b0;
    localparam logic RST_PWR_N = 1'b1;
    localparam logic RST_ALL_CHAN_STANDBY_N = 1'b1;
    localparam logic RST_ALL_CLR = 1'b0;
    localparam logic RST_CH_CHAN_STANDBY_N_N = 1'b1;
    localparam logic RST_CH_CLR = 1'b1;
    localparam logic [1:0] RST_BIAS = 2'h0;
    localparam logic [MAIN_W-1:0] MAIN_LOW_OB = 10'h000;
    localparam logic [MAIN_W-1:0] MAIN_MID_TC = 10'h000;
    localparam logic [SUB_W-1:0] SUB_ZERO_OB = 8'h80;
    localparam logic [SUB_W-1:0] SUB_ZERO_TC = 8'h00;

    typedef enum logic [1:0] {
        SDL_DST_SYS = 2'b00,
        SDL_DST_CHAN = 2'b01,
        SDL_DST_DATA = 2'b10
    } sdl_dst_e;

    typedef struct packed {
        logic coding_select;
        logic power_down_n;
        logic all_standby;
        logic all_soft_clear;
    } sdl_sys_s;

    typedef struct packed {
        logic [1:0] bias_source_select;
        logic chan_standby_n;
        logic chan_clear;
    } sdl_chan_s;
endpackage : sdl_pkg

// ---- verilog/sdl_loader.sv ----
`timescale 1ns/1ps
// Behaviour
// - three host lines in, nothing driven back
// - sample data on falling clock in frame
// - bits 13 and 14 select destination
// - decode system, channel or data write
// - system word fields at bits 6..3
// - channel word address, bias, standby, clear
// - main word carries 10-bit code
// - sub word carries 8-bit code
// - system write ignores channel address
// - channel control per addressed channel only
// - bit 15 steers main or sub
// - main ten bits, sub eight bits
// - load strobe updates all main and sub outputs together
// - clear pin resets data and outputs
// - cleared code low or midscale, sub zero
// - soft clears touch main path only
// - power down flag, registers retained
// - coding select applies to all channels
// - all standby flag, reference kept
// - address decodes channels in binary order
// - bias source select per channel
// - channel clear acts at next load
module sdl_loader (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic serial_clock_in,
    input wire logic frame_sync_n,
    input wire logic serial_data_in,
    input wire logic load_outputs_n,
    input wire logic clear_pin_n,
    output logic coding_select,
    output logic power_down_n,
    output logic all_standby,
    output logic [sdl_pkg::NUM_CH-1:0] chan_standby_n,
    output logic [sdl_pkg::NUM_CH*2-1:0] bias_source_select,
    output logic [sdl_pkg::NUM_CH*sdl_pkg::MAIN_W-1:0] main_out,
    output logic [sdl_pkg::NUM_CH*sdl_pkg::SUB_W-1:0] sub_out
);
    import sdl_pkg::*;

    // link domain: shift register on falling serial clock
    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic [4:0] cnt;
        logic [WORD_W-1:0] word;
        logic tgl;
    } sdl_link_s;

    sdl_link_s lk_q, lk_d;
    logic fs_async_q;

    // frame end has no clock edge, so frame sync resets the count
    always_ff @(negedge serial_clock_in or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            fs_async_q <= 1'b0;
        end else begin
            fs_async_q <= 1'b1;
        end
    end

    always_comb begin
        lk_d = lk_q;
        lk_d.shift = {lk_q.shift[WORD_W-2:0], serial_data_in};
        if (!fs_async_q) begin
            lk_d.cnt = 5'h01;
        end else if (lk_q.cnt != BIT_CNT_LAST) begin
            lk_d.cnt = lk_q.cnt + 5'h01;
        end
        if (lk_d.cnt == BIT_CNT_LAST && lk_q.cnt != BIT_CNT_LAST) begin
            lk_d.word = lk_d.shift;
            lk_d.tgl = ~lk_q.tgl;
        end
    end

    always_ff @(negedge serial_clock_in or negedge rstn) begin
        if (!rstn) begin
            lk_q <= '0;
        end else if (frame_sync_n) begin
            lk_q.cnt <= '0; // partial frame dropped
        end else begin
            lk_q <= lk_d;
        end
    end

    // system domain state
    typedef struct packed {
        logic [2:0] tgl_sync;
        logic [1:0] ld_sync;
        logic ld_prev;
        logic [1:0] clr_sync;
        sdl_sys_s sys;
        sdl_chan_s [NUM_CH-1:0] chan;
        logic [NUM_CH-1:0][MAIN_W-1:0] main_dat;
        logic [NUM_CH-1:0][SUB_W-1:0] sub_dat;
        logic [NUM_CH-1:0][MAIN_W-1:0] main_dac;
        logic [NUM_CH-1:0][SUB_W-1:0] sub_dac;
    } sdl_sys_state_s;

    sdl_sys_state_s st_q;
    sdl_sys_state_s st_d;
    logic [WORD_W-1:0] w;
    logic [2:0] addr;
    sdl_dst_e dst;
    logic word_new;
    logic load_edge;
    logic hard_clr;
    logic soft_clr;
    logic any_clr;
    logic [MAIN_W-1:0] main_clr;
    logic [SUB_W-1:0] sub_clr;
    sdl_sys_s sys_w;
    sdl_chan_s cc;
    logic [MAIN_W-1:0] main_code;
    logic [SUB_W-1:0] sub_code;
    logic [NUM_CH-1:0] addr_hit;
    logic [NUM_CH-1:0] main_wr;
    logic [NUM_CH-1:0] sub_wr;

    // one-hot channel select, all three address bits used
    for (genvar g = 0; g < NUM_CH; g++) begin : g_hit
        assign addr_hit[g] = (lk_q.word[ADDR_MSB:ADDR_LSB] == 3'(g));
    end

    // data wins whatever the low select bit holds
    function automatic sdl_dst_e dst_of(input logic [WORD_W-1:0] wd);
        sdl_dst_e d;
        if (wd[SEL_HI_BIT]) begin
            d = SDL_DST_DATA;
        end else if (wd[SEL_LO_BIT]) begin
            d = SDL_DST_CHAN;
        end else begin
            d = SDL_DST_SYS;
        end
        return d;
    endfunction : dst_of

    // address bits never looked at here
    function automatic sdl_sys_s sys_of(input logic [WORD_W-1:0] wd);
        sdl_sys_s s;
        s.coding_select = wd[CODING_BIT];
        s.power_down_n = wd[PWR_BIT];
        s.all_standby = wd[ALL_CHAN_STANDBY_N_BIT];
        s.all_soft_clear = wd[ALL_CLR_BIT];
        return s;
    endfunction : sys_of

    // channel word fields
    function automatic sdl_chan_s chan_of(input logic [WORD_W-1:0] wd);
        sdl_chan_s c;
        c.bias_source_select = wd[BIAS_MSB:BIAS_LSB];
        c.chan_standby_n = wd[CH_CHAN_STANDBY_N_BIT];
        c.chan_clear = wd[CH_CLR_BIT];
        return c;
    endfunction : chan_of

    // lowest level in offset binary, midscale in twos complement
    function automatic logic [MAIN_W-1:0] main_clr_of(input logic ob);
        logic [MAIN_W-1:0] m;
        if (ob) begin
            m = MAIN_LOW_OB;
        end else begin
            m = MAIN_MID_TC;
        end
        return m;
    endfunction : main_clr_of

    // sub code that adds nothing to the output
    function automatic logic [SUB_W-1:0] sub_clr_of(input logic ob);
        logic [SUB_W-1:0] s;
        if (ob) begin
            s = SUB_ZERO_OB;
        end else begin
            s = SUB_ZERO_TC;
        end
        return s;
    endfunction : sub_clr_of

    // a clear in the same cycle beats a write
    function automatic logic [MAIN_W-1:0] main_dat_next(
        input logic [MAIN_W-1:0] cur,
        input logic wr,
        input logic [MAIN_W-1:0] code,
        input logic clr,
        input logic [MAIN_W-1:0] clr_code
    );
        logic [MAIN_W-1:0] n;
        n = cur;
        if (wr) begin
            n = code;
        end
        if (clr) begin
            n = clr_code;
        end
        return n;
    endfunction : main_dat_next

    // only the hardware clear reaches the sub path
    function automatic logic [SUB_W-1:0] sub_dat_next(
        input logic [SUB_W-1:0] cur,
        input logic wr,
        input logic [SUB_W-1:0] code,
        input logic clr,
        input logic [SUB_W-1:0] clr_code
    );
        logic [SUB_W-1:0] n;
        n = cur;
        if (wr) begin
            n = code;
        end
        if (clr) begin
            n = clr_code;
        end
        return n;
    endfunction : sub_dat_next

    // channel clear bit only acts through a load
    function automatic logic [MAIN_W-1:0] main_dac_next(
        input logic [MAIN_W-1:0] cur,
        input logic ld,
        input logic [MAIN_W-1:0] dat,
        input logic chan_clr,
        input logic clr,
        input logic [MAIN_W-1:0] clr_code
    );
        logic [MAIN_W-1:0] n;
        n = cur;
        if (ld) begin
            n = chan_clr ? clr_code : dat;
        end
        if (clr) begin
            n = clr_code;
        end
        return n;
    endfunction : main_dac_next

    // sub output follows load and hardware clear
    function automatic logic [SUB_W-1:0] sub_dac_next(
        input logic [SUB_W-1:0] cur,
        input logic ld,
        input logic [SUB_W-1:0] dat,
        input logic clr,
        input logic [SUB_W-1:0] clr_code
    );
        logic [SUB_W-1:0] n;
        n = cur;
        if (ld) begin
            n = dat;
        end
        if (clr) begin
            n = clr_code;
        end
        return n;
    endfunction : sub_dac_next

    always_comb begin
        st_d = st_q;
        w = lk_q.word; // stable: only changes before its toggle crosses
        addr = w[ADDR_MSB:ADDR_LSB];
        dst = dst_of(w);
        sys_w = sys_of(w);
        cc = chan_of(w);
        main_code = w[MAIN_MSB:0];
        sub_code = w[SUB_MSB:SUB_LSB];
        main_clr = main_clr_of(st_q.sys.coding_select);
        sub_clr = sub_clr_of(st_q.sys.coding_select);
        main_wr = '0;
        sub_wr = '0;
        // two flops on every pin and on the link toggle before use
        st_d.tgl_sync = {st_q.tgl_sync[1:0], lk_q.tgl};
        st_d.ld_sync = {st_q.ld_sync[0], load_outputs_n};
        st_d.ld_prev = st_q.ld_sync[1];
        st_d.clr_sync = {st_q.clr_sync[0], clear_pin_n};
        word_new = (st_q.tgl_sync[2] != st_q.tgl_sync[1]);
        load_edge = st_q.ld_prev && !st_q.ld_sync[1];
        hard_clr = !st_q.clr_sync[1];
        soft_clr = st_q.sys.all_soft_clear;
        any_clr = soft_clr || hard_clr;
        if (word_new) begin
            case (dst)
                SDL_DST_SYS: begin
                    st_d.sys = sys_w;
                end
                SDL_DST_CHAN: begin
                    st_d.chan[addr] = cc;
                end
                SDL_DST_DATA: begin
                    if (w[FINE_SEL_BIT]) begin
                        sub_wr = addr_hit;
                    end else begin
                        main_wr = addr_hit;
                    end
                end
                default: begin
                    st_d.sys = st_q.sys;
                end
            endcase
        end
        // every channel steps in the same cycle, so a load updates all together
        for (int i = 0; i < NUM_CH; i++) begin
            st_d.main_dat[i] = main_dat_next(
                st_q.main_dat[i],
                main_wr[i],
                main_code,
                any_clr,
                main_clr
            );
            st_d.sub_dat[i] = sub_dat_next(
                st_q.sub_dat[i],
                sub_wr[i],
                sub_code,
                hard_clr,
                sub_clr
            );
            st_d.main_dac[i] = main_dac_next(
                st_q.main_dac[i],
                load_edge,
                st_q.main_dat[i],
                st_q.chan[i].chan_clear,
                any_clr,
                main_clr
            );
            st_d.sub_dac[i] = sub_dac_next(
                st_q.sub_dac[i],
                load_edge,
                st_q.sub_dat[i],
                hard_clr,
                sub_clr
            );
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.ld_sync <= 2'h3;
            st_q.ld_prev <= 1'b1;
            st_q.clr_sync <= 2'h3;
            st_q.sys.coding_select <= RST_CODING;
            st_q.sys.power_down_n <= RST_PWR_N;
            st_q.sys.all_standby <= RST_ALL_CHAN_STANDBY_N;
            st_q.sys.all_soft_clear <= RST_ALL_CLR;
            // channel clear starts set, so a load gives the clear code
            for (int i = 0; i < NUM_CH; i++) begin
                st_q.chan[i].bias_source_select <= RST_BIAS;
                st_q.chan[i].chan_standby_n <= RST_CH_CHAN_STANDBY_N_N;
                st_q.chan[i].chan_clear <= RST_CH_CLR;
                st_q.main_dat[i] <= MAIN_MID_TC;
                st_q.main_dac[i] <= MAIN_MID_TC;
                st_q.sub_dat[i] <= SUB_ZERO_TC;
                st_q.sub_dac[i] <= SUB_ZERO_TC;
            end
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops; status kept through power down
    always_comb begin
        coding_select = st_q.sys.coding_select;
        power_down_n = st_q.sys.power_down_n;
        all_standby = st_q.sys.all_standby;
        for (int i = 0; i < NUM_CH; i++) begin
            chan_standby_n[i] = st_q.chan[i].chan_standby_n;
            bias_source_select[i*2 +: 2] = st_q.chan[i].bias_source_select;
            main_out[i*MAIN_W +: MAIN_W] = st_q.main_dac[i];
            sub_out[i*SUB_W +: SUB_W] = st_q.sub_dac[i];
        end
    end
endmodule : sdl_loader

// ---- tb/sdl_loader_chk.sv ----
`timescale 1ns/1ps
module sdl_loader_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic frame_sync_n,
    input wire logic load_outputs_n,
    input wire logic clear_pin_n,
    input wire logic coding_select,
    input wire logic power_down_n,
    input wire logic all_standby,
    input wire logic [sdl_pkg::NUM_CH-1:0] chan_standby_n,
    input wire logic [sdl_pkg::NUM_CH*2-1:0] bias_source_select,
    input wire logic [sdl_pkg::NUM_CH*sdl_pkg::MAIN_W-1:0] main_out,
    input wire logic [sdl_pkg::NUM_CH*sdl_pkg::SUB_W-1:0] sub_out
);
    import sdl_pkg::*;
    // saturating ages, so state may move only shortly after a frame or a strobe
    logic [3:0] fs_age_q;
    logic [3:0] ev_age_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fs_age_q <= 4'hF;
            ev_age_q <= 4'hF;
        end else begin
            fs_age_q <= !frame_sync_n ? 4'h0 : fs_age_q + 4'(fs_age_q != 4'hF);
            ev_age_q <= !(load_outputs_n && clear_pin_n) ? 4'h0 : ev_age_q + 4'(ev_age_q != 4'hF);
        end
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    rst_cfg_a: assert property ($rose(rstn) |-> !coding_select && power_down_n && all_standby)
        else $error("config not at reset value");
    coding_chg_a: assert property ($changed(coding_select) |-> fs_age_q < 4'h8)
        else $error("coding moved without a frame");
    pwr_chg_a: assert property ($changed(power_down_n) |-> fs_age_q < 4'h8)
        else $error("power flag moved without a frame");
    chan_chg_a: assert property ($changed({chan_standby_n, bias_source_select}) |-> fs_age_q < 4'h8)
        else $error("channel config moved without a frame");
    sub_hold_a: assert property ($changed(sub_out) |-> ev_age_q < 4'h8)
        else $error("sub output moved without a strobe");
    main_hold_a: assert property ($changed(main_out) |-> ev_age_q < 4'h8 || fs_age_q < 4'h8)
        else $error("main output moved without a strobe");
    clr_main_a: assert property (!clear_pin_n [*6] |-> main_out == '0)
        else $error("main not cleared");
    clr_sub_a: assert property (!clear_pin_n [*6] |->
        sub_out == {NUM_CH{coding_select ? SUB_ZERO_OB : SUB_ZERO_TC}})
        else $error("sub not cleared");
    cover property ($fell(load_outputs_n));
    cover property (!clear_pin_n [*6] && coding_select);
    cover property ($changed(main_out) && fs_age_q < 4'h8);
endmodule : sdl_loader_chk
bind sdl_loader sdl_loader_chk chk_i (.clk_sys, .rstn, .frame_sync_n, .load_outputs_n,
    .clear_pin_n, .coding_select, .power_down_n, .all_standby, .chan_standby_n,
    .bias_source_select, .main_out, .sub_out);

// ---- tb/sdl_host.sv ----
`timescale 1ns/1ps
module sdl_host (
    output logic serial_clock_in,
    output logic frame_sync_n,
    output logic serial_data_in
);
    // clock parks high between frames, data inverts once released
    initial begin
        serial_clock_in = 1'b1;
        frame_sync_n = 1'b1;
        serial_data_in = 1'b0;
    end
    task automatic send(input logic [15:0] w, input int n);
        frame_sync_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            serial_data_in = w[i];
            #6 serial_clock_in = 1'b0;
            #6 serial_clock_in = 1'b1;
        end
        #6 frame_sync_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask : send
endmodule : sdl_host

// ---- tb/test_sdl_loader.sv ----
`timescale 1ns/1ps
module test_sdl_loader;
    import sdl_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic load_outputs_n = 1'b1;
    logic clear_pin_n = 1'b1;
    logic serial_clock_in, frame_sync_n, serial_data_in, coding_select, power_down_n, all_standby;
    logic [NUM_CH-1:0] chan_standby_n, m_chan_standby_n = '1, m_clr = '1;
    logic [NUM_CH*2-1:0] bias_source_select, m_bias = '0;
    logic [NUM_CH*MAIN_W-1:0] main_out, e_mo = '0;
    logic [NUM_CH*SUB_W-1:0] sub_out, e_so = '0;
    logic [MAIN_W-1:0] m_main [NUM_CH] = '{default: '0};
    logic [SUB_W-1:0] m_sub [NUM_CH] = '{default: '0};
    logic [3:0] m_sys = 4'h6;
    logic [31:0] seed = 32'h00000CC9;
    int n_fail = 0;
    int cmp_count = 0;
    sdl_host host (.serial_clock_in, .frame_sync_n, .serial_data_in);
    sdl_loader dut (.clk_sys, .rstn, .serial_clock_in, .frame_sync_n, .serial_data_in,
        .load_outputs_n, .clear_pin_n, .coding_select, .power_down_n, .all_standby,
        .chan_standby_n, .bias_source_select, .main_out, .sub_out);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_all();
        chk({coding_select, power_down_n, all_standby}, m_sys[3:1]);
        chk(chan_standby_n, m_chan_standby_n);
        chk(bias_source_select, m_bias);
        chk(main_out, e_mo);
        chk(sub_out, e_so);
    endtask : chk_all
    task automatic word(input logic [15:0] w);
        int a;
        a = int'(w[ADDR_MSB:ADDR_LSB]);
        host.send(w, 16);
        if (w[SEL_HI_BIT] && w[FINE_SEL_BIT]) m_sub[a] = w[SUB_MSB:SUB_LSB];
        else if (w[SEL_HI_BIT]) m_main[a] = w[MAIN_MSB:0];
        else if (w[SEL_LO_BIT]) {m_bias[2*a +: 2], m_chan_standby_n[a], m_clr[a]} = {w[BIAS_MSB:BIAS_LSB], w[CH_CHAN_STANDBY_N_BIT], w[CH_CLR_BIT]};
        else m_sys = w[CODING_BIT:ALL_CLR_BIT];
        // soft clear pins main data and outputs to the clear code
        if (m_sys[0]) e_mo = '0;
        for (int i = 0; i < NUM_CH; i++) if (m_sys[0]) m_main[i] = '0;
        repeat (8) @(posedge clk_sys);
        chk_all();
    endtask : word
    task automatic strobe(input bit hard);
        if (hard) clear_pin_n <= 1'b0;
        else load_outputs_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        clear_pin_n <= 1'b1;
        load_outputs_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < NUM_CH; i++) begin
            if (hard) m_main[i] = '0;
            if (hard) m_sub[i] = m_sys[3] ? SUB_ZERO_OB : SUB_ZERO_TC;
            e_mo[i*MAIN_W +: MAIN_W] = (m_clr[i] || m_sys[0]) ? '0 : m_main[i];
            e_so[i*SUB_W +: SUB_W] = m_sub[i];
        end
        chk_all();
    endtask : strobe
    task automatic complete_run();
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk_all();
        for (int i = 0; i < 8; i++) word({9'h000, 3'(i), 4'h0});
        word(16'h0060);
        strobe(0);
        for (int c = 0; c < NUM_CH; c++) word({3'b010, 3'(c), 10'(rnd() & 16'h03F3)});
        for (int k = 0; k < 24; k++) word(rnd() | 16'h2000);
        host.send(rnd() | 16'h2000, 10);
        repeat (8) @(posedge clk_sys);
        chk_all();
        strobe(0);
        word(16'h0068);
        word(16'h2155);
        word(16'h0060);
        strobe(0);
        for (int k = 0; k < 8; k++) word(rnd() | 16'h2000);
        strobe(1);
        word(16'h0020);
        strobe(1);
        complete_run();
    end
endmodule : test_sdl_loader
